// ==== flash_unlock_pkg.sv ====
package flash_unlock_pkg;

  // ==========================================================
  // register byte offsets on the bus
  localparam logic [11:0] PROTECT_OFS       = 12'hFF4;
  localparam logic [11:0] FLASH_COMMAND_OFS = 12'hFF8;
  localparam logic [11:0] PAGE_SELECT_OFS   = 12'hFFC;

  // ==========================================================
  // command codes
  localparam logic [7:0] KEY_FIRST      = 8'h73;
  localparam logic [7:0] KEY_SECOND     = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_PROTECT_EN = 8'h5E;

  // ==========================================================
  // reset values
  localparam logic [7:0] FLASH_COMMAND_RST = 8'h00;
  localparam logic [7:0] PROTECT_RST       = 8'h00;
  localparam logic [7:0] PAGE_SELECT_RST   = 8'h00;

  // ==========================================================
  // status byte fields
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_PROT_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  typedef enum logic [1:0] {
    LOCKED    = 2'b00,
    KEY1_SEEN = 2'b01,
    UNLOCKED  = 2'b10
  } lockState_t;

endpackage : flash_unlock_pkg

// ==== sector_protect_reg.sv ====
`timescale 1ns/1ns
module sector_protect_reg
  import flash_unlock_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         wrEn,
  input  wire logic [W-1:0] wrData,
  input  wire logic         accessEn,
  output logic      [W-1:0] protect
);

  typedef struct packed {
    logic [W-1:0] value;
  } protState_t;

  protState_t s_q;
  protState_t s_d;

  // ==========================================================
  // writes land only while access is open
  always_comb begin
    s_d = s_q;
    if (wrEn && accessEn) begin
      s_d.value = wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q.value <= PROTECT_RST[W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign protect = s_q.value;

endmodule : sector_protect_reg

// ==== unlock_seq.sv ====
`timescale 1ns/1ns
module unlock_seq
  import flash_unlock_pkg::*;
#(
  parameter int PAGE_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              cmdValid,
  input  wire logic [7:0]        cmdByte,
  input  wire logic              cmdFromDebug,
  input  wire logic              flashBusy,
  input  wire logic [PAGE_W-1:0] pageSel,
  output lockState_t             lockState,
  output logic                   pageEraseGo,
  output logic                   massEraseGo,
  output logic                   protectEnable,
  output logic      [PAGE_W-1:0] erasePage
);

  typedef struct packed {
    lockState_t        lock;
    logic              pageGo;
    logic              massGo;
    logic              protEn;
    logic [PAGE_W-1:0] page;
  } seqState_t;

  seqState_t s_q;
  seqState_t s_d;

  // ==========================================================
  // key and command sequencer
  always_comb begin
    s_d        = s_q;
    s_d.pageGo = 1'b0;
    s_d.massGo = 1'b0;
    if (cmdValid) begin
      s_d.protEn = 1'b0;
      case (s_q.lock)
        LOCKED: begin
          s_d.lock = (cmdByte == KEY_FIRST) ? KEY1_SEEN : LOCKED;
        end
        KEY1_SEEN: begin
          s_d.lock = (cmdByte == KEY_SECOND) ? UNLOCKED : LOCKED;
        end
        UNLOCKED: begin
          s_d.lock = LOCKED;
          case (cmdByte)
            CMD_PAGE_ERASE: begin
              if (!flashBusy) begin
                s_d.pageGo = 1'b1;
                s_d.page   = pageSel;
              end
            end
            CMD_MASS_ERASE: begin
              s_d.massGo = cmdFromDebug && !flashBusy;
            end
            CMD_PROTECT_EN: begin
              s_d.protEn = 1'b1;
            end
            default: begin
              s_d.lock = LOCKED;
            end
          endcase
        end
        default: begin
          s_d.lock = LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q.lock   <= LOCKED;
      s_q.pageGo <= 1'b0;
      s_q.massGo <= 1'b0;
      s_q.protEn <= 1'b0;
      s_q.page   <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lockState     = s_q.lock;
  assign pageEraseGo   = s_q.pageGo;
  assign massEraseGo   = s_q.massGo;
  assign protectEnable = s_q.protEn;
  assign erasePage     = s_q.page;

endmodule : unlock_seq

// ==== flash_command_unlock_sequencer.sv ====
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module flash_command_unlock_sequencer
  import flash_unlock_pkg::*;
#(
  parameter int PAGE_W = 8,
  parameter int PROT_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [11:0]       address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              dbgCmdValid,
  input  wire logic [7:0]        dbgCmdByte,
  input  wire logic              flashBusy,
  output logic                   pageEraseStart,
  output logic                   massEraseStart,
  output logic      [PAGE_W-1:0] erasePage,
  output logic      [PROT_W-1:0] sectorProtect
);

  typedef struct packed {
    logic              waitReq;
    logic [31:0]       rdData;
    logic [PAGE_W-1:0] pageSel;
  } busState_t;

  busState_t s_q;
  busState_t s_d;

  lockState_t  lockState;
  logic        protectEnable;
  logic        busDone;
  logic        busWrite;
  logic        cmdValid;
  logic [7:0]  cmdByte;
  logic        cmdFromDebug;
  logic        protWrite;
  logic [7:0]  statusByte;
  logic [31:0] rdMux;

  // ==========================================================
  // bus handshake: one wait cycle, then the access completes
  assign busDone  = (read || write) && !s_q.waitReq;
  assign busWrite = busDone && write && byteenable[0];

  // ==========================================================
  // command source: the debugger wins over a bus write that same cycle
  assign cmdFromDebug = dbgCmdValid;
  assign cmdValid     = dbgCmdValid || (busWrite && (address == FLASH_COMMAND_OFS));
  assign cmdByte      = dbgCmdValid ? dbgCmdByte : writedata[7:0];
  assign protWrite    = busWrite && (address == PROTECT_OFS);

  always_comb begin
    statusByte = 8'h00;
    statusByte[STAT_LOCK_LSB +: 2] = lockState;
    statusByte[STAT_PROT_BIT]      = protectEnable;
    statusByte[STAT_BUSY_BIT]      = flashBusy;
  end

  // ==========================================================
  // read decode; unmapped addresses read as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (address)
      FLASH_COMMAND_OFS: begin
        rdMux[7:0] = statusByte;
      end
      PAGE_SELECT_OFS: begin
        rdMux[PAGE_W-1:0] = s_q.pageSel;
      end
      PROTECT_OFS: begin
        rdMux[PROT_W-1:0] = sectorProtect;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    if ((read || write) && s_q.waitReq) begin
      s_d.waitReq = 1'b0;
      s_d.rdData  = read ? rdMux : 32'h0000_0000;
    end else begin
      s_d.waitReq = 1'b1;
    end
    if (busWrite && (address == PAGE_SELECT_OFS)) begin
      s_d.pageSel = writedata[PAGE_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q.waitReq <= 1'b1;
      s_q.rdData  <= 32'h0000_0000;
      s_q.pageSel <= PAGE_SELECT_RST[PAGE_W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata    = s_q.rdData;
  assign waitrequest = s_q.waitReq;

  // ==========================================================
  // sequencer and protect register
  unlock_seq #(
    .PAGE_W (PAGE_W)
  ) u_seq (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .cmdValid      (cmdValid),
    .cmdByte       (cmdByte),
    .cmdFromDebug  (cmdFromDebug),
    .flashBusy     (flashBusy),
    .pageSel       (s_q.pageSel),
    .lockState     (lockState),
    .pageEraseGo   (pageEraseStart),
    .massEraseGo   (massEraseStart),
    .protectEnable (protectEnable),
    .erasePage     (erasePage)
  );

  sector_protect_reg #(
    .W (PROT_W)
  ) u_prot (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .wrEn     (protWrite),
    .wrData   (writedata[PROT_W-1:0]),
    .accessEn (protectEnable),
    .protect  (sectorProtect)
  );

  // ==========================================================
  // checks
  property p_lockAfterReset;
    @(posedge clk_sys) disable iff (srst)
      $fell(srst) |-> (lockState == LOCKED);
  endproperty
  a_lockAfterReset: assert property (p_lockAfterReset)
    else $error("not locked after reset");

  property p_pageNeedsUnlock;
    @(posedge clk_sys) disable iff (srst)
      pageEraseStart |-> ($past(lockState) == UNLOCKED) && $past(cmdValid)
        && ($past(cmdByte) == CMD_PAGE_ERASE);
  endproperty
  a_pageNeedsUnlock: assert property (p_pageNeedsUnlock)
    else $error("page erase without unlock and 95H");

  property p_firstKey;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (cmdByte == KEY_FIRST) && (lockState == LOCKED))
        |=> (lockState == KEY1_SEEN);
  endproperty
  a_firstKey: assert property (p_firstKey)
    else $error("first key not taken");

  property p_unlockPair;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (cmdByte == KEY_SECOND) && (lockState == KEY1_SEEN))
        |=> (lockState == UNLOCKED);
  endproperty
  a_unlockPair: assert property (p_unlockPair)
    else $error("key pair did not unlock");

  property p_pageSelected;
    @(posedge clk_sys) disable iff (srst)
      pageEraseStart |-> (erasePage == $past(s_q.pageSel));
  endproperty
  a_pageSelected: assert property (p_pageSelected)
    else $error("erase page differs from page select");

  property p_massCause;
    @(posedge clk_sys) disable iff (srst)
      massEraseStart |-> ($past(cmdByte) == CMD_MASS_ERASE)
        && ($past(lockState) == UNLOCKED) && $past(cmdValid);
  endproperty
  a_massCause: assert property (p_massCause)
    else $error("mass erase without unlock and 63H");

  property p_massDebugOnly;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && !cmdFromDebug) |=> !massEraseStart;
  endproperty
  a_massDebugOnly: assert property (p_massDebugOnly)
    else $error("mass erase from cpu software");

  property p_protectOpen;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (cmdByte == CMD_PROTECT_EN) && (lockState == UNLOCKED))
        |=> protectEnable && (lockState == LOCKED);
  endproperty
  a_protectOpen: assert property (p_protectOpen)
    else $error("5EH did not open protect access");

  property p_protectGuard;
    @(posedge clk_sys) disable iff (srst)
      (protWrite && !protectEnable) |=> $stable(sectorProtect);
  endproperty
  a_protectGuard: assert property (p_protectGuard)
    else $error("protect register written while closed");

  property p_badSecondKey;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (lockState == KEY1_SEEN) && (cmdByte != KEY_SECOND))
        |=> (lockState == LOCKED) && !pageEraseStart && !massEraseStart;
  endproperty
  a_badSecondKey: assert property (p_badSecondKey)
    else $error("wrong second byte did not lock");

  property p_lockedStays;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (lockState == LOCKED) && (cmdByte != KEY_FIRST))
        |=> (lockState == LOCKED) && !pageEraseStart && !massEraseStart;
  endproperty
  a_lockedStays: assert property (p_lockedStays)
    else $error("invalid byte left controller unlocked");

  property p_relock;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (lockState == UNLOCKED)) |=> (lockState == LOCKED);
  endproperty
  a_relock: assert property (p_relock)
    else $error("no relock after command");

  property p_statusRead;
    @(posedge clk_sys) disable iff (srst)
      (busDone && read && (address == FLASH_COMMAND_OFS))
        |-> (readdata[7:0] == $past(statusByte)) && (readdata[31:8] == 24'h00_0000);
  endproperty
  a_statusRead: assert property (p_statusRead)
    else $error("status read mismatch");

  property p_readNoEffect;
    @(posedge clk_sys) disable iff (srst)
      (busDone && read && !dbgCmdValid) |=> $stable(lockState);
  endproperty
  a_readNoEffect: assert property (p_readNoEffect)
    else $error("read changed sequencer");

  property p_pageEarly;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (cmdByte == CMD_PAGE_ERASE) && (lockState != UNLOCKED))
        |=> (lockState == LOCKED) && !pageEraseStart;
  endproperty
  a_pageEarly: assert property (p_pageEarly)
    else $error("95H out of place started an erase");

  property p_pageGo;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && (cmdByte == CMD_PAGE_ERASE) && (lockState == UNLOCKED) && !flashBusy)
        |=> pageEraseStart && (erasePage == $past(s_q.pageSel));
  endproperty
  a_pageGo: assert property (p_pageGo)
    else $error("third byte 95H did not start a page erase");

  property p_massGo;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && cmdFromDebug && (cmdByte == CMD_MASS_ERASE) && (lockState == UNLOCKED) && !flashBusy)
        |=> massEraseStart;
  endproperty
  a_massGo: assert property (p_massGo)
    else $error("debugger 63H did not start a mass erase");

  property p_busyNoStart;
    @(posedge clk_sys) disable iff (srst)
      (cmdValid && flashBusy) |=> !pageEraseStart && !massEraseStart;
  endproperty
  a_busyNoStart: assert property (p_busyNoStart)
    else $error("erase started while flash busy");

  property p_protectWrite;
    @(posedge clk_sys) disable iff (srst)
      (protWrite && protectEnable) |=> (sectorProtect == $past(writedata[PROT_W-1:0]));
  endproperty
  a_protectWrite: assert property (p_protectWrite)
    else $error("open protect register ignored a write");

  property p_readHolds;
    @(posedge clk_sys) disable iff (srst)
      !((read || write) && waitrequest) |=> $stable(readdata);
  endproperty
  a_readHolds: assert property (p_readHolds)
    else $error("read data changed without an access");

  property p_waitOne;
    @(posedge clk_sys) disable iff (srst)
      ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest;
  endproperty
  a_waitOne: assert property (p_waitOne)
    else $error("bus answer not after one wait cycle");

endmodule : flash_command_unlock_sequencer

// ==== tb.sv ====
`timescale 1ns/1ns
module tb
  import flash_unlock_pkg::*;
;
  // ==========================================================
  // stimulus table
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic       dbg;
    logic       pg;
    logic       ms;
    logic [3:0] st;
  } row_t;

  localparam row_t ROWS [9] = '{
    '{8'h73, 8'h8C, 8'h95, 1'b0, 1'b1, 1'b0, 4'h0},
    '{8'h73, 8'h8C, 8'h63, 1'b0, 1'b0, 1'b0, 4'h0},
    '{8'h73, 8'h8C, 8'h63, 1'b1, 1'b0, 1'b1, 4'h0},
    '{8'h73, 8'h8C, 8'h5E, 1'b0, 1'b0, 1'b0, 4'h4},
    '{8'h73, 8'h8C, 8'h95, 1'b1, 1'b1, 1'b0, 4'h0},
    '{8'h95, 8'h73, 8'h8C, 1'b0, 1'b0, 1'b0, 4'h2},
    '{8'h73, 8'h8C, 8'h95, 1'b0, 1'b0, 1'b0, 4'h0},
    '{8'h73, 8'h95, 8'h8C, 1'b0, 1'b0, 1'b0, 4'h0},
    '{8'h12, 8'h95, 8'h00, 1'b0, 1'b0, 1'b0, 4'h0}
  };

  logic        clk_sys;
  logic        srst;
  logic [11:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        dbgCmdValid;
  logic [7:0]  dbgCmdByte;
  logic        flashBusy;
  logic        pageEraseStart;
  logic        massEraseStart;
  logic [7:0]  erasePage;
  logic [7:0]  sectorProtect;
  int          errTotal;
  int          nTests;
  int          pageCnt;
  int          massCnt;
  int          p0;
  int          m0;
  logic [31:0] q;

  flash_command_unlock_sequencer i_flash_command_unlock_sequencer (
    .clk_sys(clk_sys), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .dbgCmdValid(dbgCmdValid), .dbgCmdByte(dbgCmdByte),
    .flashBusy(flashBusy), .pageEraseStart(pageEraseStart), .massEraseStart(massEraseStart),
    .erasePage(erasePage), .sectorProtect(sectorProtect)
  );

  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  // start pulses are counted so one-cycle pulses are never missed
  always @(posedge clk_sys) begin
    if (pageEraseStart === 1'b1) pageCnt <= pageCnt + 1;
    if (massEraseStart === 1'b1) massCnt <= massCnt + 1;
  end

  // ==========================================================
  // tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("tests %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    @(posedge clk_sys);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    write      <= wr;
    read       <= ~wr;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (waitrequest === 1'b0) break;
    end
    if (k == 50) begin
      check("waitrequest", 32'(waitrequest), 32'h0);
      end_of_test();
    end
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask : xfer

  task automatic cmd(input logic [7:0] b, input logic dbg);
    if (dbg) begin
      @(posedge clk_sys);
      dbgCmdValid <= 1'b1;
      dbgCmdByte  <= b;
      @(posedge clk_sys);
      dbgCmdValid <= 1'b0;
    end else begin
      xfer(1'b1, FLASH_COMMAND_OFS, b, 4'hF);
    end
  endtask : cmd

  task automatic settle_mark;
    repeat (3) @(posedge clk_sys);
    p0 = pageCnt;
    m0 = massCnt;
  endtask : settle_mark

  // ==========================================================
  // main sequence
  initial begin
    {srst, read, write, dbgCmdValid, flashBusy} <= 5'b10000;
    {address, writedata, byteenable, dbgCmdByte} <= '0;
    {errTotal, nTests, pageCnt, massCnt} = '0;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
    check("statusReset", q, 32'h0);
    check("protectReset", 32'(sectorProtect), 32'h0);
    foreach (ROWS[i]) begin
      settle_mark();
      cmd(ROWS[i].b0, 1'b0);
      cmd(ROWS[i].b1, 1'b0);
      cmd(ROWS[i].b2, ROWS[i].dbg);
      repeat (3) @(posedge clk_sys);
      check("pageStarts", 32'(pageCnt - p0), 32'(ROWS[i].pg));
      check("massStarts", 32'(massCnt - m0), 32'(ROWS[i].ms));
      xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
      check("status", q, {28'h0, ROWS[i].st});
    end
    // erase hits the selected page only, and needs a fresh key after it
    xfer(1'b1, PAGE_SELECT_OFS, 8'h5A, 4'hF);
    settle_mark();
    cmd(8'h73, 1'b0);
    cmd(8'h8C, 1'b0);
    cmd(8'h95, 1'b0);
    cmd(8'h95, 1'b0);
    repeat (3) @(posedge clk_sys);
    check("erasePage", 32'(erasePage), 32'h5A);
    check("pageStarts", 32'(pageCnt - p0), 32'h1);
    // status shares the command address
    cmd(8'h73, 1'b0);
    xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
    check("statusKey1", q, 32'h1);
    cmd(8'h8C, 1'b0);
    xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
    check("statusOpen", q, 32'h2);
    cmd(8'h12, 1'b0);
    // protect register only writable while access is open
    xfer(1'b1, PROTECT_OFS, 8'hA5, 4'hF);
    xfer(1'b0, PROTECT_OFS, 8'h00, 4'hF);
    check("protectClosed", q, 32'h0);
    cmd(8'h73, 1'b0);
    cmd(8'h8C, 1'b0);
    cmd(8'h5E, 1'b0);
    xfer(1'b1, PROTECT_OFS, 8'hA5, 4'hF);
    xfer(1'b0, PROTECT_OFS, 8'h00, 4'hF);
    check("protectOpen", q, 32'hA5);
    // busy flash refuses an erase start
    flashBusy <= 1'b1;
    settle_mark();
    cmd(8'h73, 1'b0);
    cmd(8'h8C, 1'b0);
    cmd(8'h95, 1'b0);
    xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
    check("statusBusy", q, 32'h8);
    check("busyStarts", 32'(pageCnt - p0), 32'h0);
    flashBusy <= 1'b0;
    xfer(1'b0, 12'h100, 8'h00, 4'hF);
    check("unmapped", q, 32'h0);
    xfer(1'b1, FLASH_COMMAND_OFS, 8'h73, 4'hE);
    xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
    check("laneOff", q, 32'h0);
    // reset in mid-sequence relocks
    cmd(8'h73, 1'b0);
    cmd(8'h8C, 1'b0);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    xfer(1'b0, FLASH_COMMAND_OFS, 8'h00, 4'hF);
    check("statusMidReset", q, 32'h0);
    check("protectMidReset", 32'(sectorProtect), 32'h0);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    end_of_test();
  end
endmodule : tb
